// ===== common/zfs_pkg.sv
// Package for the zone fault sharing node: node types, error categories, reset values.
// Assumes a single 50 MHz clock domain and an active-low asynchronous reset.
package zfs_pkg;

	// Two-bit node type code, values 0..3 select types 1..4
	typedef enum logic [1:0]
	{
		ZFS_TYPE_1 = 2'h0,
		ZFS_TYPE_2 = 2'h1,
		ZFS_TYPE_3 = 2'h2,
		ZFS_TYPE_4 = 2'h3
	} zfs_node_type;

	// Diagnostic category codes of a local error report
	localparam logic [1:0] ZFS_CAT_NONE = 2'h0;
	localparam logic [1:0] ZFS_CAT_F3   = 2'h1;
	localparam logic [1:0] ZFS_CAT_F7   = 2'h2;
	localparam logic [1:0] ZFS_CAT_F83  = 2'h3;

	localparam zfs_node_type ZFS_TYPE_RST     = ZFS_TYPE_4;
	localparam logic         ZFS_ZONE_ERR_RST = 1'h0;

	// One-hot node state
	typedef enum logic [2:0]
	{
		ZFS_ST_IDLE   = 3'h1,
		ZFS_ST_WARN   = 3'h2,
		ZFS_ST_LOCAL  = 3'h4
	} zfs_state_type;

endpackage

// ===== common/zfs_cfg_if.sv
// Interface carrying the decoded inject and react bits from the config holder to the node.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface zfs_cfg_if;
	logic inject;
	logic react;
	modport holder (output inject, output react);
	modport node   (input  inject, input  react);
endinterface
`default_nettype wire

// ===== core/zfs_cfg.sv
// Holds the node type, loaded by a strobe, and decodes its inject and react bits.
// Assumes the load strobe and type are synchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none
module zfs_cfg
(
	input  wire logic                 clk_i,
	input  wire logic                 resetn_i,
	input  wire logic                 load_i,
	input  wire zfs_pkg::zfs_node_type type_i,
	output var zfs_pkg::zfs_node_type  type_o,
	zfs_cfg_if.holder                 cfg
);
	import zfs_pkg::*;

	zfs_node_type node_type;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			node_type <= ZFS_TYPE_RST;
		else if (load_i)
			node_type <= type_i;
	end

	assign type_o = node_type;
	assign cfg.inject = (node_type == ZFS_TYPE_1) || (node_type == ZFS_TYPE_2);
	assign cfg.react  = (node_type == ZFS_TYPE_1) || (node_type == ZFS_TYPE_3);

	property p_cfg_hold;
		@(posedge clk_i) disable iff (!resetn_i)
		!load_i |=> $stable(node_type);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("node type changed without load");

endmodule // zfs_cfg
`default_nettype wire

// ===== core/zfs_node.sv
// Zone fault sharing node: forwards or injects zone error, raises warning and reaction.
// Assumes zone bus input and local error inputs are synchronous to clk_i.
//
// Functional notes
// - Each node holds one of four types
// - Types 1,2 inject local error downstream
// - Types 1,2 error-free forward previous status
// - Types 3,4 always forward, never inject
// - Types 1,3 warn and react if error-free
// - Warning holds while incoming zone error holds
// - Types 2,4 never warn nor react
// - Zone error persists until injectors clear
// - Warning-only node recovers automatically
// - Local error means F3, F7, F83 category
`timescale 1ns/100ps
`default_nettype none
module zfs_node
(
	input  wire logic                  clk_i,
	input  wire logic                  resetn_i,
	input  wire logic                  cfg_load_i,
	input  wire zfs_pkg::zfs_node_type cfg_type_i,
	input  wire logic [1:0]            local_err_cat_i,
	input  wire logic                  zone_err_in_i,
	output logic                       zone_err_out_o,
	output logic                       zone_fault_warning_o,
	output logic                       error_reaction_o,
	output logic                       local_err_o,
	output var zfs_pkg::zfs_node_type  node_type_o
);
	import zfs_pkg::*;

	zfs_cfg_if     cfg_bus();
	zfs_node_type  type_q;
	zfs_state_type state;
	zfs_state_type next_state;

	zfs_cfg u_cfg
	(
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.load_i   (cfg_load_i),
		.type_i   (cfg_type_i),
		.type_o   (type_q),
		.cfg      (cfg_bus.holder)
	);

	wire local_err = (local_err_cat_i == ZFS_CAT_F3) || (local_err_cat_i == ZFS_CAT_F7)
		|| (local_err_cat_i == ZFS_CAT_F83);

	wire next_zone_out = (cfg_bus.inject && local_err) ? 1'h1 : zone_err_in_i;

	wire warn_cond = cfg_bus.react && zone_err_in_i && !local_err;

	always_comb
	begin
		next_state = ZFS_ST_IDLE;
		if (local_err)
			next_state = ZFS_ST_LOCAL;
		else if (warn_cond)
			next_state = ZFS_ST_WARN;
	end

	// Reaction is a level like the warning; a pulse would be lost if the bus error stays
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state                <= ZFS_ST_IDLE;
			zone_err_out_o       <= ZFS_ZONE_ERR_RST;
			zone_fault_warning_o <= 1'h0;
			error_reaction_o     <= 1'h0;
			local_err_o          <= 1'h0;
		end
		else
		begin
			state                <= next_state;
			zone_err_out_o       <= next_zone_out;
			zone_fault_warning_o <= warn_cond;
			error_reaction_o     <= warn_cond;
			local_err_o          <= local_err;
		end
	end

	// Type is registered in the holder, so it comes straight from a flip-flop
	assign node_type_o = type_q;

	// Persistence is the injector holding its local error; this node forwards each cycle
	property p_inject;
		@(posedge clk_i) disable iff (!resetn_i)
		(cfg_bus.inject && local_err) |=> zone_err_out_o;
	endproperty
	a_inject: assert property (p_inject)
		else $error("local error not injected");

	sequence s_inject_held;
		cfg_bus.inject && local_err ##1
		cfg_bus.inject && local_err;
	endsequence
	property p_inject_hold;
		@(posedge clk_i) disable iff (!resetn_i)
		s_inject_held |=> zone_err_out_o && $past(zone_err_out_o);
	endproperty
	a_inject_hold: assert property (p_inject_hold)
		else $error("zone error dropped while local error held");

	property p_forward;
		@(posedge clk_i) disable iff (!resetn_i)
		(cfg_bus.inject && !local_err) |=> (zone_err_out_o == $past(zone_err_in_i));
	endproperty
	a_forward: assert property (p_forward)
		else $error("error-free injector did not forward");

	property p_no_inject;
		@(posedge clk_i) disable iff (!resetn_i)
		!cfg_bus.inject |=> (zone_err_out_o == $past(zone_err_in_i));
	endproperty
	a_no_inject: assert property (p_no_inject)
		else $error("non-injecting node altered the zone status");

	property p_type3_local;
		@(posedge clk_i) disable iff (!resetn_i)
		(type_q == ZFS_TYPE_3 && local_err)
			|=> (zone_err_out_o == $past(zone_err_in_i)) && !zone_fault_warning_o;
	endproperty
	a_type3_local: assert property (p_type3_local)
		else $error("type 3 node injected or warned on local error");

	property p_type4_inert;
		@(posedge clk_i) disable iff (!resetn_i)
		(type_q == ZFS_TYPE_4)
			|=> (zone_err_out_o == $past(zone_err_in_i)) && !zone_fault_warning_o
				&& !error_reaction_o;
	endproperty
	a_type4_inert: assert property (p_type4_inert)
		else $error("type 4 node altered the bus or warned");

	property p_react;
		@(posedge clk_i) disable iff (!resetn_i)
		(cfg_bus.react && zone_err_in_i && !local_err)
			|=> (zone_fault_warning_o && error_reaction_o);
	endproperty
	a_react: assert property (p_react)
		else $error("reacting node did not warn");

	property p_local_quiet;
		@(posedge clk_i) disable iff (!resetn_i)
		local_err |=> !zone_fault_warning_o && !error_reaction_o;
	endproperty
	a_local_quiet: assert property (p_local_quiet)
		else $error("node with local error warned");

	sequence s_bus_err_held;
		zone_err_in_i && cfg_bus.react && !local_err ##1
		zone_err_in_i && cfg_bus.react && !local_err;
	endsequence
	property p_warn_hold;
		@(posedge clk_i) disable iff (!resetn_i)
		s_bus_err_held |=> zone_fault_warning_o && $past(zone_fault_warning_o);
	endproperty
	a_warn_hold: assert property (p_warn_hold)
		else $error("warning dropped while zone error held");

	property p_no_bus_quiet;
		@(posedge clk_i) disable iff (!resetn_i)
		!zone_err_in_i |=> !zone_fault_warning_o && !error_reaction_o;
	endproperty
	a_no_bus_quiet: assert property (p_no_bus_quiet)
		else $error("warning raised without zone error");

	property p_ignore;
		@(posedge clk_i) disable iff (!resetn_i)
		!cfg_bus.react |=> !zone_fault_warning_o && !error_reaction_o;
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("non-reacting node warned");

	property p_recover;
		@(posedge clk_i) disable iff (!resetn_i)
		(zone_fault_warning_o && !zone_err_in_i) |=> !zone_fault_warning_o;
	endproperty
	a_recover: assert property (p_recover)
		else $error("warning did not clear after bus error ended");

	property p_idle;
		@(posedge clk_i) disable iff (!resetn_i)
		(!zone_err_in_i && (local_err_cat_i == ZFS_CAT_NONE)) |=> (state == ZFS_ST_IDLE);
	endproperty
	a_idle: assert property (p_idle)
		else $error("node not idle with bus and local error clear");

	property p_local;
		@(posedge clk_i) disable iff (!resetn_i)
		(local_err_cat_i == ZFS_CAT_NONE) |=> !local_err_o && !state[2];
	endproperty
	a_local: assert property (p_local)
		else $error("local error flagged without category");

	property p_local_flag;
		@(posedge clk_i) disable iff (!resetn_i)
		(local_err_cat_i != ZFS_CAT_NONE) |=> local_err_o && (state == ZFS_ST_LOCAL);
	endproperty
	a_local_flag: assert property (p_local_flag)
		else $error("local error category not flagged");

	property p_type_load;
		@(posedge clk_i) disable iff (!resetn_i)
		cfg_load_i |=> (node_type_o == $past(cfg_type_i));
	endproperty
	a_type_load: assert property (p_type_load)
		else $error("node type not taken on load");

endmodule // zfs_node
`default_nettype wire

// ===== tb/zfs_zone_end.sv
// Model of the zone module at the end of the chain.
// Assumes its zone input comes straight from the last node.
`timescale 1ns/100ps
`default_nettype none
module zfs_zone_end
(
	input  wire logic       zone_err_i,
	output logic      [1:0] pair_o
);
	assign pair_o = {2{zone_err_i}};
endmodule // zfs_zone_end
`default_nettype wire

// ===== tb/tb_zone_error_propagation_node.sv
// Testbench of the zone fault sharing node, table rows then hand cases.
// Assumes inputs change at the falling edge, one cycle output latency.
`timescale 1ns/100ps
`default_nettype none
module tb_zone_error_propagation_node;
	import zfs_pkg::*;
	logic         clk, resetn, load, zin, zout, warn, react, lerr;
	zfs_node_type ntype, node_type;
	logic [1:0]   cat, pair;
	int           fails = 0;
	int           check_count = 0;
	// Row bits: type, category, zone in, expected out, expected warning
	logic [6:0]   rows [11] = '{7'h0A, 7'h07, 7'h00, 7'h32, 7'h26, 7'h58,
		7'h47, 7'h4E, 7'h70, 7'h66, 7'h1E};

	zfs_node i_dut (.clk_i(clk), .resetn_i(resetn), .cfg_load_i(load), .cfg_type_i(ntype),
		.local_err_cat_i(cat), .zone_err_in_i(zin), .zone_err_out_o(zout),
		.zone_fault_warning_o(warn), .error_reaction_o(react), .local_err_o(lerr),
		.node_type_o(node_type));
	zfs_zone_end i_end (.zone_err_i(zout), .pair_o(pair));

	initial
	begin
		clk = 0;
		forever #10 clk = ~clk;
	end

	task chk(input string nm, input logic [1:0] e, input logic [1:0] g);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task load_type(input zfs_node_type t, input logic [1:0] c, input logic z);
		@(negedge clk);
		load = 1;
		ntype = t;
		cat = c;
		zin = z;
		@(negedge clk);
		load = 0;
	endtask

	initial
	begin
		resetn = 0; load = 1; ntype = ZFS_TYPE_1; cat = 0; zin = 1;
		repeat (4) @(negedge clk);
		chk("rst_type", 2'h3, node_type);
		chk("rst_out", 2'h0, {zout, warn});
		resetn = 1;
		foreach (rows[i])
		begin
			load_type(zfs_node_type'(rows[i][6:5]), rows[i][4:3], rows[i][2]);
			chk("type", rows[i][6:5], node_type);
			@(negedge clk);
			chk("out_warn", rows[i][1:0], {zout, warn});
			chk("react_local", {rows[i][0], |rows[i][4:3]}, {react, lerr});
			chk("pair", {2{rows[i][1]}}, pair);
		end
		load_type(ZFS_TYPE_1, ZFS_CAT_NONE, 1'h1);
		repeat (5)
		begin
			@(negedge clk);
			chk("warn_hold", 2'h3, {warn, react});
		end
		zin = 0;
		@(negedge clk);
		chk("warn_clear", 2'h0, {warn, react});
		load_type(ZFS_TYPE_2, ZFS_CAT_F83, 1'h0);
		repeat (4)
		begin
			@(negedge clk);
			chk("inject_hold", 2'h1, {warn, zout});
		end
		cat = ZFS_CAT_NONE;
		@(negedge clk);
		chk("inject_clear", 2'h0, {warn, zout});
		resetn = 0;
		#1;
		chk("midrun_rst", 2'h3, node_type);
		wrap_up;
	end

	initial
	begin
		#5000;
		fails++;
		wrap_up;
	end
endmodule // tb_zone_error_propagation_node
`default_nettype wire
